//--- core/cdc_core.sv
// execution of clear-accumulator, clear-watchdog, decrement-file and complement-file opcodes
//
// Contract
// [RULE1] fixed clear opcode loads zero into accumulator and sets zero flag, one cycle
// [RULE2] fixed watchdog opcode resets watchdog counter to zero in one cycle
// [RULE3] watchdog opcode also resets the watchdog prescaler to zero together
// [RULE4] watchdog opcode sets timeout and powerdown status bits (active low) to one
// [RULE5] decrement pattern subtracts one from addressed file register, updates zero, one cycle
// [RULE6] destination bit zero writes accumulator, one writes the addressed file register
// [RULE7] complement pattern inverts addressed file register, routes by destination, updates zero
// [RULE8] zero flag follows eight-bit result; low seven opcode bits select file register
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "cdc_cfg.svh"

module cdc_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // axi4-lite write address and data
    input wire logic [7:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    // axi4-lite write response
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // axi4-lite read
    input wire logic [7:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // core status
    output logic timeout_status_n_out,
    output logic powerdown_status_n_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    cdc_pkg::cdc_byte_t acc;
    logic zero_flag;
    cdc_pkg::cdc_byte_t file_reg [0:127];
    logic [6:0] file_addr;
    cdc_pkg::cdc_byte_t watchdog_counter;
    cdc_pkg::cdc_byte_t watchdog_prescaler;
    logic exec_valid;
    cdc_pkg::cdc_opcode_t exec_opcode;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic cdc_pkg::cdc_op_e decode_op(input cdc_pkg::cdc_opcode_t opc);
        if (opc == `CDC_OPC_CLEAR_ACC) begin
            return cdc_pkg::CDC_OP_CLEAR_ACC;
        end else if (opc == `CDC_OPC_CLEAR_WATCHDOG) begin
            return cdc_pkg::CDC_OP_CLEAR_WATCHDOG;
        end else if (opc[13:8] == `CDC_PAT_DECREMENT) begin
            return cdc_pkg::CDC_OP_DECREMENT;
        end else if (opc[13:8] == `CDC_PAT_COMPLEMENT) begin
            return cdc_pkg::CDC_OP_COMPLEMENT;
        end else begin
            return cdc_pkg::CDC_OP_NONE;
        end
    endfunction : decode_op

    // the accumulator, file address and file data use only the low byte lane; the opcode spans bits 13:0
    function automatic cdc_pkg::cdc_byte_t merge_low(input cdc_pkg::cdc_byte_t old, input logic [31:0] data,
                                                     input logic [3:0] strb);
        return strb[0] ? data[7:0] : old;
    endfunction : merge_low

    // ----------------------------------------
    // execution datapath
    // ----------------------------------------
    cdc_pkg::cdc_op_e exec_op;
    cdc_pkg::cdc_byte_t operand;
    cdc_pkg::cdc_byte_t result;
    logic exec_to_file;
    logic exec_to_acc;
    logic sw_write;
    logic [7:0] sw_ofs;

    always_comb begin
        exec_op = exec_valid ? decode_op(exec_opcode) : cdc_pkg::CDC_OP_NONE;
        operand = file_reg[exec_opcode[6:0]]; // [RULE8]
        result = `CDC_RST_BYTE;
        exec_to_file = 1'b0;
        exec_to_acc = 1'b0;
        case (exec_op)
            cdc_pkg::CDC_OP_DECREMENT: begin
                result = operand - 8'h01; // [RULE5]
                exec_to_file = exec_opcode[`CDC_DEST_BIT]; // [RULE6]
                exec_to_acc = ~exec_opcode[`CDC_DEST_BIT];
            end
            cdc_pkg::CDC_OP_COMPLEMENT: begin
                result = ~operand; // [RULE7]
                exec_to_file = exec_opcode[`CDC_DEST_BIT]; // [RULE6]
                exec_to_acc = ~exec_opcode[`CDC_DEST_BIT];
            end
            default: begin
                result = `CDC_RST_BYTE;
            end
        endcase
    end

    assign sw_write = aw_full && w_full && !s_bvalid_out;
    assign sw_ofs = aw_addr;

    // opcode written by software executes on the following edge
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            exec_valid <= 1'b0;
            exec_opcode <= 14'h0000;
        end else begin
            exec_valid <= sw_write && (sw_ofs == `CDC_OFS_OPCODE);
            if (sw_write && (sw_ofs == `CDC_OFS_OPCODE)) begin
                exec_opcode <= w_data[13:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc <= `CDC_RST_BYTE;
            zero_flag <= 1'b0;
        end else if (exec_op == cdc_pkg::CDC_OP_CLEAR_ACC) begin
            acc <= `CDC_RST_BYTE; // [RULE1]
            zero_flag <= 1'b1; // [RULE1]
        end else if (exec_to_acc || exec_to_file) begin
            if (exec_to_acc) begin
                acc <= result; // [RULE6]
            end
            zero_flag <= (result == `CDC_RST_BYTE); // [RULE8]
        end else if (sw_write && sw_ofs == `CDC_OFS_ACC) begin
            acc <= merge_low(acc, w_data, w_strb);
        end
    end

    always_ff @(posedge clk_in) begin
        if (exec_to_file) begin
            file_reg[exec_opcode[6:0]] <= result; // [RULE6]
        end else if (sw_write && sw_ofs == `CDC_OFS_FILE_DATA && w_strb[0]) begin
            file_reg[file_addr] <= w_data[7:0];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            file_addr <= 7'h00;
        end else if (sw_write && sw_ofs == `CDC_OFS_FILE_ADDR && w_strb[0]) begin
            file_addr <= w_data[6:0];
        end
    end

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // prescaler wrap is the slow tick enable for the counter
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            watchdog_prescaler <= `CDC_RST_BYTE;
            watchdog_counter <= `CDC_RST_BYTE;
        end else if (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG) begin
            watchdog_prescaler <= `CDC_RST_BYTE; // [RULE3]
            watchdog_counter <= `CDC_RST_BYTE; // [RULE2]
        end else begin
            watchdog_prescaler <= watchdog_prescaler + 8'h01;
            if (watchdog_prescaler == 8'hff) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    // clearing the watchdog also empties the counter, so a wrap cannot race it
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timeout_status_n_out <= `CDC_RST_STATUS_N;
            powerdown_status_n_out <= `CDC_RST_STATUS_N;
        end else if (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG) begin
            timeout_status_n_out <= 1'b1; // [RULE4]
            powerdown_status_n_out <= 1'b1; // [RULE4]
        end else if (watchdog_prescaler == 8'hff && watchdog_counter == 8'hff) begin
            timeout_status_n_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_awready_out <= 1'b1;
            s_wready_out <= 1'b1;
            s_bvalid_out <= 1'b0;
            s_bresp_out <= `CDC_RESP_OKAY;
        end else begin
            if (s_awvalid_in && s_awready_out) begin
                aw_full <= 1'b1;
                aw_addr <= {s_awaddr_in[7:2], 2'b00};
                s_awready_out <= 1'b0;
            end
            if (s_wvalid_in && s_wready_out) begin
                w_full <= 1'b1;
                w_data <= s_wdata_in;
                w_strb <= s_wstrb_in;
                s_wready_out <= 1'b0;
            end
            if (sw_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_bvalid_out <= 1'b1;
                if (sw_ofs == `CDC_OFS_OPCODE || sw_ofs == `CDC_OFS_ACC ||
                    sw_ofs == `CDC_OFS_FILE_ADDR || sw_ofs == `CDC_OFS_FILE_DATA) begin
                    s_bresp_out <= `CDC_RESP_OKAY;
                end else begin
                    s_bresp_out <= `CDC_RESP_SLVERR;
                end
            end else if (s_bvalid_out && s_bready_in) begin
                s_bvalid_out <= 1'b0;
                s_awready_out <= 1'b1;
                s_wready_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_arready_out <= 1'b1;
            s_rvalid_out <= 1'b0;
            s_rdata_out <= 32'h00000000;
            s_rresp_out <= `CDC_RESP_OKAY;
        end else if (s_arvalid_in && s_arready_out) begin
            s_arready_out <= 1'b0;
            s_rvalid_out <= 1'b1;
            s_rresp_out <= `CDC_RESP_OKAY;
            s_rdata_out <= 32'h00000000;
            if (s_araddr_in[7:2] == `CDC_OFS_OPCODE >> 2) begin
                s_rdata_out <= {18'h00000, exec_opcode};
            end else if (s_araddr_in[7:2] == `CDC_OFS_ACC >> 2) begin
                s_rdata_out <= {24'h000000, acc};
            end else if (s_araddr_in[7:2] == `CDC_OFS_STATUS >> 2) begin
                s_rdata_out <= {29'h00000000, powerdown_status_n_out, timeout_status_n_out, zero_flag};
            end else if (s_araddr_in[7:2] == `CDC_OFS_WATCHDOG >> 2) begin
                s_rdata_out <= {16'h0000, watchdog_prescaler, watchdog_counter};
            end else if (s_araddr_in[7:2] == `CDC_OFS_FILE_ADDR >> 2) begin
                s_rdata_out <= {25'h0000000, file_addr};
            end else if (s_araddr_in[7:2] == `CDC_OFS_FILE_DATA >> 2) begin
                s_rdata_out <= {24'h000000, file_reg[file_addr]};
            end else begin
                s_rresp_out <= `CDC_RESP_SLVERR;
            end
        end else if (s_rvalid_out && s_rready_in) begin
            s_rvalid_out <= 1'b0;
            s_arready_out <= 1'b1;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cdc_cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    clear_acc_a: assert property (exec_op == cdc_pkg::CDC_OP_CLEAR_ACC |=> acc == 8'h00 && zero_flag) // [RULE1]
        else $error("accumulator clear did not zero accumulator and set zero");
    clear_wd_count_a: assert property (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG |=> watchdog_counter == 8'h00) // [RULE2]
        else $error("watchdog counter not cleared");
    clear_wd_presc_a: assert property (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG |=> watchdog_prescaler == 8'h00) // [RULE3]
        else $error("watchdog prescaler not cleared");
    clear_wd_status_a: assert property (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG
        |=> timeout_status_n_out && powerdown_status_n_out ##1 powerdown_status_n_out) // [RULE4]
        else $error("status bits not set by watchdog clear");
    dec_file_a: assert property (exec_op == cdc_pkg::CDC_OP_DECREMENT && exec_opcode[7]
        |=> file_reg[$past(exec_opcode[6:0])] == $past(operand) - 8'h01) // [RULE5]
        else $error("decrement to file wrong");
    dest_acc_a: assert property ((exec_op == cdc_pkg::CDC_OP_DECREMENT || exec_op == cdc_pkg::CDC_OP_COMPLEMENT)
        && !exec_opcode[7] |=> acc == $past(result) && file_reg[$past(exec_opcode[6:0])] == $past(operand)) // [RULE6]
        else $error("destination zero did not go to accumulator only");
    comp_value_a: assert property (exec_op == cdc_pkg::CDC_OP_COMPLEMENT && exec_opcode[7]
        |=> file_reg[$past(exec_opcode[6:0])] == ~$past(operand)) // [RULE7]
        else $error("complement to file wrong");
    zero_flag_a: assert property (exec_to_acc || exec_to_file |=> zero_flag == ($past(result) == 8'h00)) // [RULE8]
        else $error("zero flag does not follow result");

    clear_acc_c: cover property (exec_op == cdc_pkg::CDC_OP_CLEAR_ACC);
    dec_to_zero_c: cover property (exec_op == cdc_pkg::CDC_OP_DECREMENT && operand == 8'h01);
    comp_to_acc_c: cover property (exec_op == cdc_pkg::CDC_OP_COMPLEMENT && !exec_opcode[7]);
    clear_wd_c: cover property (exec_op == cdc_pkg::CDC_OP_CLEAR_WATCHDOG && !timeout_status_n_out);

endmodule : cdc_core

//--- shared/cdc_cfg.svh
// constants for the clear, decrement and complement execution block
`ifndef CDC_CFG_SVH
`define CDC_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CDC_OFS_OPCODE 8'h00
`define CDC_OFS_ACC 8'h04
`define CDC_OFS_STATUS 8'h08
`define CDC_OFS_WATCHDOG 8'h0c
`define CDC_OFS_FILE_ADDR 8'h10
`define CDC_OFS_FILE_DATA 8'h14

// ----------------------------------------
// status field positions
// ----------------------------------------
`define CDC_STATUS_ZERO_BIT 0
`define CDC_STATUS_TIMEOUT_BIT 1
`define CDC_STATUS_POWERDOWN_BIT 2

// ----------------------------------------
// opcodes and patterns
// ----------------------------------------
`define CDC_OPC_CLEAR_ACC 14'h0103
`define CDC_OPC_CLEAR_WATCHDOG 14'h0064
`define CDC_PAT_DECREMENT 6'h03
`define CDC_PAT_COMPLEMENT 6'h09
`define CDC_DEST_BIT 7

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define CDC_RST_BYTE 8'h00
`define CDC_RST_STATUS_N 1'b1
`define CDC_RESP_OKAY 2'h0
`define CDC_RESP_SLVERR 2'h2

`endif

//--- shared/cdc_pkg.sv
// types for the clear, decrement and complement execution block
package cdc_pkg;
    typedef logic [13:0] cdc_opcode_t;
    typedef logic [7:0] cdc_byte_t;

    typedef enum logic [4:0] {
        CDC_OP_NONE = 5'h01,
        CDC_OP_CLEAR_ACC = 5'h02,
        CDC_OP_CLEAR_WATCHDOG = 5'h04,
        CDC_OP_DECREMENT = 5'h08,
        CDC_OP_COMPLEMENT = 5'h10
    } cdc_op_e;
endpackage : cdc_pkg

//--- tb/cdc_core_tb.sv
// self-checking bench for the clear, decrement and complement execution block
`timescale 1ns/1ns
`include "cdc_cfg.svh"

`define TB_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR t=%0t mismatch got %h exp %h", $time, (got), (exp)); end end

module cdc_core_tb;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] s_awaddr_in = 8'h00;
    logic s_awvalid_in = 1'b0;
    logic s_awready_out;
    logic [31:0] s_wdata_in = 32'h0;
    logic [3:0] s_wstrb_in = 4'h0;
    logic s_wvalid_in = 1'b0;
    logic s_wready_out;
    logic [1:0] s_bresp_out;
    logic s_bvalid_out;
    logic s_bready_in = 1'b0;
    logic [7:0] s_araddr_in = 8'h00;
    logic s_arvalid_in = 1'b0;
    logic s_arready_out;
    logic [31:0] s_rdata_out;
    logic [1:0] s_rresp_out;
    logic s_rvalid_out;
    logic s_rready_in = 1'b0;
    logic timeout_status_n_out;
    logic powerdown_status_n_out;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;

    cdc_core i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .s_awaddr_in(s_awaddr_in), .s_awvalid_in(s_awvalid_in), .s_awready_out(s_awready_out),
        .s_wdata_in(s_wdata_in), .s_wstrb_in(s_wstrb_in), .s_wvalid_in(s_wvalid_in), .s_wready_out(s_wready_out),
        .s_bresp_out(s_bresp_out), .s_bvalid_out(s_bvalid_out), .s_bready_in(s_bready_in),
        .s_araddr_in(s_araddr_in), .s_arvalid_in(s_arvalid_in), .s_arready_out(s_arready_out),
        .s_rdata_out(s_rdata_out), .s_rresp_out(s_rresp_out), .s_rvalid_out(s_rvalid_out),
        .s_rready_in(s_rready_in),
        .timeout_status_n_out(timeout_status_n_out), .powerdown_status_n_out(powerdown_status_n_out)
    );

    always #4 clk_in = ~clk_in;

    // ----------------------------------------
    // closing report and hang guard
    // ----------------------------------------
    task summarize;
        $display("compares %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // the watchdog expiry wait alone takes about 66k cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            $display("ERROR t=%0t bench timeout", $time);
            summarize();
        end
    end

    // ----------------------------------------
    // axi4-lite master tasks, entered just after a rising edge
    // ----------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_awaddr_in <= a;
        s_awvalid_in <= 1'b1;
        s_wdata_in <= d;
        s_wstrb_in <= 4'hf;
        s_wvalid_in <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_in);
            if (!aw_ok && s_awready_out === 1'b1) begin
                aw_ok = 1'b1;
                s_awvalid_in <= 1'b0;
            end
            if (!w_ok && s_wready_out === 1'b1) begin
                w_ok = 1'b1;
                s_wvalid_in <= 1'b0;
            end
        end
        s_bready_in <= 1'b1;
        do @(posedge clk_in); while (s_bvalid_out !== 1'b1);
        `TB_CHK(s_bresp_out, exp_resp)
        s_bready_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] exp_resp);
        s_araddr_in <= a;
        s_arvalid_in <= 1'b1;
        do @(posedge clk_in); while (s_arready_out !== 1'b1);
        s_arvalid_in <= 1'b0;
        s_rready_in <= 1'b1;
        do @(posedge clk_in); while (s_rvalid_out !== 1'b1);
        d = s_rdata_out;
        `TB_CHK(s_rresp_out, exp_resp)
        s_rready_in <= 1'b0;
    endtask : reg_rd

    // ----------------------------------------
    // file operation cases; zero flag alternates so a stuck flag shows
    // ----------------------------------------
    localparam int NCASE = 5;
    logic [5:0] c_pat[NCASE] = '{`CDC_PAT_DECREMENT, `CDC_PAT_DECREMENT, `CDC_PAT_COMPLEMENT,
                                 `CDC_PAT_COMPLEMENT, `CDC_PAT_DECREMENT};
    logic c_dst[NCASE] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [6:0] c_idx[NCASE] = '{7'h05, 7'h7f, 7'h00, 7'h13, 7'h05};
    logic [7:0] c_val[NCASE] = '{8'h01, 8'h00, 8'hff, 8'h13, 8'h00};
    logic [7:0] c_acc[NCASE] = '{8'h00, 8'h5a, 8'h5a, 8'hec, 8'h5a};
    logic [7:0] c_file[NCASE] = '{8'h01, 8'hff, 8'h00, 8'h13, 8'hff};
    logic c_zero[NCASE] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        `TB_CHK({timeout_status_n_out, powerdown_status_n_out}, 2'b11)
        reg_rd(`CDC_OFS_ACC, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[7:0], 8'h00)
        reg_rd(`CDC_OFS_STATUS, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[2:0], 3'b110)
        reg_wr(8'h18, 32'h0000_00a5, `CDC_RESP_SLVERR);
        reg_wr(`CDC_OFS_STATUS, 32'h0, `CDC_RESP_SLVERR);
        reg_rd(8'h18, rd, `CDC_RESP_SLVERR);
        `TB_CHK(rd, 32'h0)
        $display("test bus and reset done");

        // neighbour of a used index, must survive every operation
        reg_wr(`CDC_OFS_FILE_ADDR, 32'h06, `CDC_RESP_OKAY);
        reg_wr(`CDC_OFS_FILE_DATA, 32'h77, `CDC_RESP_OKAY);
        for (int i = 0; i < NCASE; i++) begin
            if (i == 4) begin
                reg_wr(`CDC_OFS_ACC, 32'h5a, `CDC_RESP_OKAY);
                reg_wr(`CDC_OFS_OPCODE, {18'h0, `CDC_OPC_CLEAR_ACC}, `CDC_RESP_OKAY);
                reg_rd(`CDC_OFS_ACC, rd, `CDC_RESP_OKAY);
                `TB_CHK(rd[7:0], 8'h00)
                reg_rd(`CDC_OFS_STATUS, rd, `CDC_RESP_OKAY);
                `TB_CHK(rd[0], 1'b1)
            end
            reg_wr(`CDC_OFS_ACC, 32'h5a, `CDC_RESP_OKAY);
            reg_wr(`CDC_OFS_FILE_ADDR, {25'h0, c_idx[i]}, `CDC_RESP_OKAY);
            reg_wr(`CDC_OFS_FILE_DATA, {24'h0, c_val[i]}, `CDC_RESP_OKAY);
            reg_wr(`CDC_OFS_OPCODE, {18'h0, c_pat[i], c_dst[i], c_idx[i]}, `CDC_RESP_OKAY);
            reg_rd(`CDC_OFS_ACC, rd, `CDC_RESP_OKAY);
            `TB_CHK(rd[7:0], c_acc[i])
            reg_rd(`CDC_OFS_FILE_DATA, rd, `CDC_RESP_OKAY);
            `TB_CHK(rd[7:0], c_file[i])
            reg_rd(`CDC_OFS_STATUS, rd, `CDC_RESP_OKAY);
            `TB_CHK(rd[0], c_zero[i])
        end
        reg_wr(`CDC_OFS_FILE_ADDR, 32'h06, `CDC_RESP_OKAY);
        reg_rd(`CDC_OFS_FILE_DATA, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[7:0], 8'h77)
        $display("test file operations done");

        // ----------------------------------------
        // watchdog: clear, let it expire, clear again
        // ----------------------------------------
        repeat (600) @(posedge clk_in);
        reg_rd(`CDC_OFS_WATCHDOG, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[7:0] !== 8'h00, 1'b1)
        reg_wr(`CDC_OFS_OPCODE, {18'h0, `CDC_OPC_CLEAR_WATCHDOG}, `CDC_RESP_OKAY);
        reg_rd(`CDC_OFS_WATCHDOG, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[7:0], 8'h00)
        `TB_CHK(rd[15:8] < 8'h08, 1'b1)
        repeat (65000) @(posedge clk_in);
        `TB_CHK(timeout_status_n_out, 1'b1)
        repeat (1000) @(posedge clk_in);
        `TB_CHK(timeout_status_n_out, 1'b0)
        reg_wr(`CDC_OFS_OPCODE, {18'h0, `CDC_OPC_CLEAR_WATCHDOG}, `CDC_RESP_OKAY);
        reg_rd(`CDC_OFS_STATUS, rd, `CDC_RESP_OKAY);
        `TB_CHK(rd[2:1], 2'b11)
        `TB_CHK({timeout_status_n_out, powerdown_status_n_out}, 2'b11)
        $display("test watchdog done");
        summarize();
    end
endmodule : cdc_core_tb
